// ===== include/fce_map.svh
// Register offsets, field positions, command codes and timing counts for the flash command checker
// Summary of operation
// - Flash address write before clock divider is loaded sets access error and aborts.
// - Byte write or odd-address word write to flash sets access error and aborts.
// - Starting a sequence during compress or erase-abort activity sets access error.
// - Further step-one addresses must match the first relative address, else access error.
// - After an address write, writing any register but command sets access error.
// - Second command code or undefined command code sets access error and aborts.
// - Secured part: non-mass-erase command from non-secure source or debug sets access error.
// - After command write, address write or non-status register write sets access error.
// - Writing 0 to the buffer-empty flag aborts the sequence and sets access error.
// - Register reads during a valid sequence never set access error.
// - Erase-abort launched during sector erase ends it early and sets access error.
// - Stop mode during an operation aborts it, purges buffered command, sets access error.
// - Array reads while command complete is 0 return invalid data, no access error.
// - Protected program/sector erase or protected-block mass erase sets protection violation.
// - Lock configuration register is read-only and loaded from configuration byte at reset.
// - Backdoor enable field bits 7:6; only 10 enables backdoor key access.
// - Lock state bits 1:0; only 10 is unsecured; backdoor unlock forces 10.
// - Erase verify: address write, command 0x05, then write 1 to buffer-empty flag.
// - Same relative address in several blocks erase verifies them together.
// - Erase verify takes block addresses plus 14 cycles; completion waits for buffered command.
// - Blank flag set only if all erased; stops at first unerased; margin bits apply.
`ifndef FCE_MAP_SVH
`define FCE_MAP_SVH
`define FCE_REG_CLKDIV    8'h00
`define FCE_REG_LOCKCFG   8'h01
`define FCE_REG_TSTMOD    8'h02
`define FCE_REG_STAT      8'h05
`define FCE_REG_CMD       8'h06
`define FCE_STAT_COMMAND_BUFFER_EMPTY_FLAG    7
`define FCE_STAT_COMMAND_COMPLETE_FLAG     6
`define FCE_STAT_PROTECTION_VIOLATION_FLAG    5
`define FCE_STAT_ACCESS_ERROR_FLAG   4
`define FCE_STAT_BLANK    2
`define FCE_CLKDIV_LOADED 7
`define FCE_KEYEN_HI      7
`define FCE_KEYEN_LO      6
`define FCE_LOCK_HI       1
`define FCE_LOCK_LO       0
`define FCE_KEY_ON        2'h2
`define FCE_UNSECURED     2'h2
`define FCE_CMD_VERIFY    8'h05
`define FCE_CMD_COMPRESS  8'h06
`define FCE_CMD_PROGRAM   8'h20
`define FCE_CMD_SECTERA   8'h40
`define FCE_CMD_MASSERA   8'h41
`define FCE_CMD_ERAABORT  8'h47
`define FCE_EV_OVERHEAD   14
`define FCE_OP_CYCLES     32
`define FCE_ABORT_CYCLES  8
`define FCE_SECTERA_CYCLES 1000
`endif

// ===== include/fce_pkg.sv
// Types shared by the flash command checker
package fce_pkg;
  typedef struct packed {
    logic [17:0] addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
    logic        byteWr;
  } fceBusReq_s;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_ADDR = 2'b01,
    SEQ_CMD  = 2'b10
  } fceSeq_e;

  typedef logic [19:0] fceCount_t;
endpackage

// ===== rtl/fce_checker.sv
// Flash command write sequencer with illegal-step checking and erase verify engine
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "fce_map.svh"
module fce_checker #(
  parameter int BLOCK_WORDS    = 16384,
  parameter int OP_CYCLES      = `FCE_OP_CYCLES,
  parameter int SECTERA_CYCLES = `FCE_SECTERA_CYCLES,
  parameter int ABORT_CYCLES   = `FCE_ABORT_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire fce_pkg::fceBusReq_s busReq,
  output logic [15:0]             rdata,
  input  wire logic [15:0]        arrayRdData,
  input  wire logic [7:0]         cfgLockByte,
  input  wire logic               backdoorUnlock,
  input  wire logic               nonSecureSrc,
  input  wire logic               debugMode,
  input  wire logic               stopReq,
  input  wire logic               protHit,
  input  wire logic               blockProtAny,
  input  wire logic               verifyErased,
  output logic [13:0]             verifyAddr,
  output logic [3:0]              verifySel,
  output logic [1:0]              senseMargin,
  output logic [7:0]              activeCmd,
  output logic                    opActive
);
  import fce_pkg::*;

  fceSeq_e     seqState;
  fceSeq_e     next_seqState;
  logic [6:0]  clkDiv;
  logic        divLoaded;
  logic [7:0]  lockCfg;
  logic [1:0]  read_margin_select;
  logic        access_error_flag;
  logic        protViol;
  logic        blank;
  logic [13:0] seqRel;
  logic [3:0]  seqMask;
  logic        seqProt;
  logic        seqBlkProt;
  logic [7:0]  seqCmd;
  logic        pendValid;
  logic [7:0]  pendCmd;
  logic [3:0]  pendMask;
  logic        busy;
  logic [7:0]  opCmd;
  fceCount_t   cnt;
  fceCount_t   opLen;

  logic        arrWr;
  logic        regWr;
  logic        arrRd;
  logic [7:0]  off;
  logic [3:0]  blkOneHot;
  logic        command_buffer_empty_flag;
  logic        command_complete_flag;
  logic        secured;
  logic        seqErr;
  logic        pviolHit;
  logic        launch;
  logic        abortHit;
  logic        stopAbort;
  logic        evFail;
  logic        opDone;
  logic        startNew;

  function automatic logic cmdValid(input logic [7:0] c);
    cmdValid = (c == `FCE_CMD_VERIFY) || (c == `FCE_CMD_COMPRESS) || (c == `FCE_CMD_PROGRAM) ||
               (c == `FCE_CMD_SECTERA) || (c == `FCE_CMD_MASSERA) || (c == `FCE_CMD_ERAABORT);
  endfunction

  function automatic fceCount_t opLength(input logic [7:0] c);
    unique case (c)
      `FCE_CMD_VERIFY:   opLength = fceCount_t'(BLOCK_WORDS + `FCE_EV_OVERHEAD);
      `FCE_CMD_SECTERA:  opLength = fceCount_t'(SECTERA_CYCLES);
      `FCE_CMD_MASSERA:  opLength = fceCount_t'(SECTERA_CYCLES);
      `FCE_CMD_ERAABORT: opLength = fceCount_t'(ABORT_CYCLES);
      default:           opLength = fceCount_t'(OP_CYCLES);
    endcase
  endfunction

  // Bus decode: bit 17 selects the array window, bits 16:15 the block
  assign arrWr     = busReq.we && busReq.addr[17];
  assign regWr     = busReq.we && !busReq.addr[17];
  assign arrRd     = busReq.re && busReq.addr[17];
  assign off       = busReq.addr[7:0];
  assign blkOneHot = 4'h1 << busReq.addr[16:15];

  // Buffer empty while no launched command waits behind a running one
  assign command_buffer_empty_flag   = !pendValid;
  assign command_complete_flag    = !busy && !pendValid;
  assign secured = lockCfg[`FCE_LOCK_HI:`FCE_LOCK_LO] != `FCE_UNSECURED;

  // Illegal step detection; reads never reach this logic
  always_comb begin
    next_seqState = seqState;
    seqErr        = 1'b0;
    pviolHit      = 1'b0;
    launch        = 1'b0;
    if (arrWr && !access_error_flag && command_buffer_empty_flag) begin
      unique case (seqState)
        SEQ_IDLE: begin
          if (!divLoaded) begin
            seqErr = 1'b1;
          end else if (busReq.byteWr || busReq.addr[0]) begin
            seqErr = 1'b1;
          end else if (busy && (opCmd == `FCE_CMD_COMPRESS || opCmd == `FCE_CMD_ERAABORT)) begin
            seqErr = 1'b1;
          end else begin
            next_seqState = SEQ_ADDR;
          end
        end
        SEQ_ADDR: begin
          if (busReq.byteWr || busReq.addr[0]) begin
            seqErr = 1'b1;
          end else if (busReq.addr[14:1] != seqRel) begin
            seqErr = 1'b1;
          end
        end
        SEQ_CMD: begin
          seqErr = 1'b1;
        end
        default: begin
          seqErr = 1'b1;
        end
      endcase
    end else if (regWr) begin
      unique case (seqState)
        SEQ_IDLE: begin
          next_seqState = SEQ_IDLE;
        end
        SEQ_ADDR: begin
          if (off != `FCE_REG_CMD) begin
            seqErr = 1'b1;
          end else if (!cmdValid(busReq.wdata[7:0])) begin
            seqErr = 1'b1;
          end else if (secured && busReq.wdata[7:0] != `FCE_CMD_MASSERA && (nonSecureSrc || debugMode)) begin
            seqErr = 1'b1;
          end else if ((busReq.wdata[7:0] == `FCE_CMD_PROGRAM || busReq.wdata[7:0] == `FCE_CMD_SECTERA)
                       && seqProt) begin
            pviolHit = 1'b1;
          end else if (busReq.wdata[7:0] == `FCE_CMD_MASSERA && seqBlkProt) begin
            pviolHit = 1'b1;
          end else begin
            next_seqState = SEQ_CMD;
          end
        end
        SEQ_CMD: begin
          if (off != `FCE_REG_STAT) begin
            seqErr = 1'b1;
          end else if (!busReq.wdata[`FCE_STAT_COMMAND_BUFFER_EMPTY_FLAG]) begin
            seqErr = 1'b1;
          end else begin
            launch        = 1'b1;
            next_seqState = SEQ_IDLE;
          end
        end
        default: begin
          seqErr = 1'b1;
        end
      endcase
    end
    if (seqErr || pviolHit) begin
      next_seqState = SEQ_IDLE;
    end
  end

  assign abortHit  = launch && busy && opCmd == `FCE_CMD_SECTERA && seqCmd == `FCE_CMD_ERAABORT;
  assign stopAbort = stopReq && (busy || pendValid);
  assign evFail    = busy && opCmd == `FCE_CMD_VERIFY && cnt < fceCount_t'(BLOCK_WORDS) && !verifyErased;
  assign opDone    = busy && (cnt == opLen - fceCount_t'(1) || evFail);
  assign startNew  = launch && !busy && !stopReq;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      seqState <= SEQ_IDLE;
    end else if (stopReq) begin
      seqState <= SEQ_IDLE;
    end else begin
      seqState <= next_seqState;
    end
  end

  // Step-one capture: relative address, block set and protection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      seqRel     <= 14'h0000;
      seqMask    <= 4'h0;
      seqProt    <= 1'b0;
      seqBlkProt <= 1'b0;
    end else if (arrWr && !seqErr && seqState == SEQ_IDLE && next_seqState == SEQ_ADDR) begin
      seqRel     <= busReq.addr[14:1];
      seqMask    <= blkOneHot;
      seqProt    <= protHit;
      seqBlkProt <= blockProtAny;
    end else if (arrWr && !seqErr && seqState == SEQ_ADDR) begin
      seqMask    <= seqMask | blkOneHot;
      seqProt    <= seqProt | protHit;
      seqBlkProt <= seqBlkProt | blockProtAny;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      seqCmd <= 8'h00;
    end else if (regWr && seqState == SEQ_ADDR && next_seqState == SEQ_CMD) begin
      seqCmd <= busReq.wdata[7:0];
    end
  end

  // Clock divider: any write with no sequence open marks it loaded
  always_ff @(posedge clk) begin
    if (!nrst) begin
      clkDiv    <= 7'h00;
      divLoaded <= 1'b0;
    end else if (regWr && off == `FCE_REG_CLKDIV && seqState == SEQ_IDLE) begin
      clkDiv    <= busReq.wdata[6:0];
      divLoaded <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      read_margin_select <= 2'h0;
    end else if (regWr && off == `FCE_REG_TSTMOD && seqState == SEQ_IDLE) begin
      read_margin_select <= busReq.wdata[1:0];
    end
  end

  // Lock configuration: no bus write path; sampled from the configuration byte while reset holds
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lockCfg <= cfgLockByte;
    end else if (backdoorUnlock && lockCfg[`FCE_KEYEN_HI:`FCE_KEYEN_LO] == `FCE_KEY_ON) begin
      lockCfg[`FCE_LOCK_HI:`FCE_LOCK_LO] <= `FCE_UNSECURED;
    end
  end

  // Error flags: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      access_error_flag <= 1'b0;
    end else if (seqErr || abortHit || stopAbort) begin
      access_error_flag <= 1'b1;
    end else if (regWr && off == `FCE_REG_STAT && busReq.wdata[`FCE_STAT_ACCESS_ERROR_FLAG]) begin
      access_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      protViol <= 1'b0;
    end else if (pviolHit) begin
      protViol <= 1'b1;
    end else if (regWr && off == `FCE_REG_STAT && busReq.wdata[`FCE_STAT_PROTECTION_VIOLATION_FLAG]) begin
      protViol <= 1'b0;
    end
  end

  // One-deep command buffer behind the running operation
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pendValid <= 1'b0;
      pendCmd   <= 8'h00;
      pendMask  <= 4'h0;
    end else if (stopReq) begin
      pendValid <= 1'b0;
    end else if (launch && busy && !abortHit) begin
      pendValid <= 1'b1;
      pendCmd   <= seqCmd;
      pendMask  <= seqMask;
    end else if (opDone) begin
      pendValid <= 1'b0;
    end
  end

  // Operation engine; erase verify walks one word per cycle first, then the fixed tail
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy      <= 1'b0;
      opCmd     <= 8'h00;
      cnt       <= '0;
      opLen     <= '0;
      verifySel <= 4'h0;
    end else if (stopAbort) begin
      busy <= 1'b0;
    end else if (abortHit) begin
      opCmd <= `FCE_CMD_ERAABORT;
      cnt   <= '0;
      opLen <= opLength(`FCE_CMD_ERAABORT);
    end else if (opDone) begin
      if (pendValid) begin
        opCmd     <= pendCmd;
        cnt       <= '0;
        opLen     <= opLength(pendCmd);
        verifySel <= pendMask;
      end else begin
        busy <= 1'b0;
      end
    end else if (busy) begin
      cnt <= cnt + fceCount_t'(1);
    end else if (startNew) begin
      busy      <= 1'b1;
      opCmd     <= seqCmd;
      cnt       <= '0;
      opLen     <= opLength(seqCmd);
      verifySel <= seqMask;
    end
  end

  // Blank result: cleared at each start, set only when a verify runs to its end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      blank <= 1'b0;
    end else if (startNew || (opDone && pendValid)) begin
      blank <= 1'b0;
    end else if (opDone && opCmd == `FCE_CMD_VERIFY && !evFail) begin
      blank <= 1'b1;
    end
  end

  // Read port; array data is replaced while an algorithm runs
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (arrRd) begin
      rdata <= command_complete_flag ? arrayRdData : 16'h0000;
    end else if (busReq.re) begin
      unique case (off)
        `FCE_REG_CLKDIV:  rdata <= {8'h00, divLoaded, clkDiv};
        `FCE_REG_LOCKCFG: rdata <= {8'h00, lockCfg};
        `FCE_REG_TSTMOD:  rdata <= {14'h0000, read_margin_select};
        `FCE_REG_STAT:    rdata <= {8'h00, command_buffer_empty_flag, command_complete_flag, protViol, access_error_flag, 1'b0, blank, 2'h0};
        `FCE_REG_CMD:     rdata <= {8'h00, seqCmd};
        default:          rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // Scan address only meaningful during the walk phase
  assign verifyAddr  = cnt[13:0];
  assign senseMargin = read_margin_select;
  assign activeCmd   = opCmd;
  assign opActive    = busy;
endmodule

// ===== dv/fce_checker_sva.sv
// Port-level assertions for the flash command checker
`timescale 1ns/1ps
module fce_checker_sva #(
  parameter int BLOCK_WORDS  = 16384,
  parameter int ABORT_CYCLES = 8
) (
  input wire logic                clk,
  input wire logic                nrst,
  input wire fce_pkg::fceBusReq_s busReq,
  input wire logic [15:0]         rdata,
  input wire logic                stopReq,
  input wire logic                verifyErased,
  input wire logic [13:0]         verifyAddr,
  input wire logic [7:0]          activeCmd,
  input wire logic                opActive
);
  import fce_pkg::*;
  localparam int ABORT_MAX = ABORT_CYCLES + 2;
  int evCnt;
  // Busy cycles since launch, zero while idle
  always_ff @(posedge clk) begin
    if (!nrst || !opActive) begin
      evCnt <= 0;
    end else begin
      evCnt <= evCnt + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  read_quiet_a: assert property (!$past(busReq.re) |-> rdata == 16'h0000)
    else $error("read data outside the answer cycle");
  busy_read_a: assert property ($past(busReq.re && busReq.addr[17] && opActive) |-> rdata == 16'h0000)
    else $error("array read while busy returned data");
  stop_abort_a: assert property (stopReq |=> !opActive)
    else $error("engine still busy after stop");
  abort_short_a: assert property ($rose(opActive && activeCmd == 8'h47) |-> ##[1:ABORT_MAX] !(opActive && activeCmd == 8'h47))
    else $error("erase abort ran too long");
  verify_start_a: assert property ($rose(opActive) && activeCmd == 8'h05 |-> verifyAddr == 14'h0000)
    else $error("verify walk did not start at zero");
  // Scan index steps by one; the fixed tail keeps counting past the block, so no range bound
  verify_range_a: assert property (opActive && activeCmd == 8'h05 && $past(opActive && activeCmd == 8'h05)
    |-> verifyAddr == 14'($past(verifyAddr) + 14'h0001) || verifyAddr == 14'h0000)
    else $error("verify address did not step by one");
  verify_stop_a: assert property (opActive && activeCmd == 8'h05 && !verifyErased |-> ##[1:2] !opActive)
    else $error("verify went on past an unerased word");
  verify_time_a: assert property ($fell(opActive) && $past(activeCmd) == 8'h05 && $past(verifyErased)
    |-> evCnt == BLOCK_WORDS + 14)
    else $error("verify length wrong");
  cover property (opActive && activeCmd == 8'h05);
  cover property (stopReq && opActive);
  cover property (opActive && activeCmd == 8'h47);
endmodule
bind fce_checker fce_checker_sva #(.BLOCK_WORDS(BLOCK_WORDS), .ABORT_CYCLES(ABORT_CYCLES)) u_fce_checker_sva (
  .clk(clk), .nrst(nrst), .busReq(busReq), .rdata(rdata), .stopReq(stopReq), .verifyErased(verifyErased),
  .verifyAddr(verifyAddr), .activeCmd(activeCmd), .opActive(opActive)
);

// ===== dv/fce_host.sv
// Bus master model issuing flash command write sequences
`timescale 1ns/1ps
module fce_host (
  input  wire logic           clk,
  input  wire logic [15:0]    rdata,
  output fce_pkg::fceBusReq_s busReq
);
  import fce_pkg::*;
  initial busReq = '0;
  // Strobe stands one cycle, released only after the taking edge
  task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic b);
    @(posedge clk);
    busReq <= '{a, d, 1'b1, 1'b0, b};
    @(posedge clk);
    busReq <= '0;
  endtask
  task automatic rd(input logic [17:0] a, output logic [15:0] d);
    @(posedge clk);
    busReq <= '{a, 16'h0000, 1'b0, 1'b1, 1'b0};
    @(posedge clk);
    busReq <= '0;
    #1 d = rdata;
  endtask
  task automatic launch(input logic [17:0] a, input logic [7:0] c);
    wr(a, 16'h0000, 1'b0);
    wr(18'h00006, {8'h00, c}, 1'b0);
    wr(18'h00005, 16'h0080, 1'b0);
  endtask
  // Stale flags would poison the next sequence
  task automatic clr();
    wr(18'h00005, 16'h0030, 1'b0);
  endtask
endmodule

// ===== dv/tb_fce_checker.sv
// Self-checking bench for the flash command checker
`timescale 1ns/1ps
module tb_fce_checker;
  import fce_pkg::*;
  localparam int NW = 16;
  localparam logic [17:0] A = 18'h20000;
  localparam logic [17:0] K = 18'h00000;
  localparam logic [17:0] L = 18'h00001;
  localparam logic [17:0] S = 18'h00005;
  localparam logic [17:0] C = 18'h00006;
  localparam logic [17:0] N = 18'h3ffff;
  // Flags: byte, protHit, blockProt, expected violation, expected access error
  typedef struct packed {
    logic [17:0] a1;
    logic [17:0] a2;
    logic [7:0]  d2;
    logic [17:0] a3;
    logic [7:0]  d3;
    logic [4:0]  f;
  } fceRow_s;
  fceRow_s rows [14] = '{
    '{A, C, 8'h05, N, 8'h00, 5'b00000}, '{A, C, 8'h05, N, 8'h00, 5'b10001},
    '{18'h20001, C, 8'h05, N, 8'h00, 5'b00001}, '{A, C, 8'h11, N, 8'h00, 5'b00001},
    '{A, K, 8'h08, N, 8'h00, 5'b00001}, '{A, 18'h28002, 8'h00, N, 8'h00, 5'b00001},
    '{A, C, 8'h20, N, 8'h00, 5'b01110}, '{A, C, 8'h40, N, 8'h00, 5'b01110},
    '{A, C, 8'h41, N, 8'h00, 5'b00110}, '{A, C, 8'h20, N, 8'h00, 5'b00000},
    '{A, C, 8'h05, 18'h20004, 8'h00, 5'b00001}, '{A, C, 8'h05, K, 8'h08, 5'b00001},
    '{A, C, 8'h05, S, 8'h00, 5'b00001}, '{A, C, 8'h05, C, 8'h05, 5'b00001}
  };
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  cfgLockByte = 8'hfe;
  logic        protHit = 1'b0, blockProtAny = 1'b0, nonSecureSrc = 1'b0, debugMode = 1'b0;
  logic        stopReq = 1'b0, backdoorUnlock = 1'b0;
  logic [15:0] arrayRdData = 16'h1234;
  logic [14:0] badIdx = 15'h7fff;
  fceBusReq_s  busReq;
  logic [15:0] rdata, s;
  logic [13:0] verifyAddr;
  logic [3:0]  verifySel;
  logic [1:0]  senseMargin;
  logic [7:0]  activeCmd;
  logic        opActive;
  int          errors = 0, tests_run = 0, n;
  // Array model: every word erased except the one at badIdx
  wire logic   verifyErased = {1'b0, verifyAddr} != badIdx;
  always #10 clk = ~clk;
  fce_checker #(.BLOCK_WORDS(NW), .OP_CYCLES(40), .SECTERA_CYCLES(200), .ABORT_CYCLES(12)) u_fce_checker (
    .clk(clk), .nrst(nrst), .busReq(busReq), .rdata(rdata), .arrayRdData(arrayRdData),
    .cfgLockByte(cfgLockByte), .backdoorUnlock(backdoorUnlock), .nonSecureSrc(nonSecureSrc),
    .debugMode(debugMode), .stopReq(stopReq), .protHit(protHit), .blockProtAny(blockProtAny),
    .verifyErased(verifyErased), .verifyAddr(verifyAddr), .verifySel(verifySel),
    .senseMargin(senseMargin), .activeCmd(activeCmd), .opActive(opActive));
  fce_host u_fce_host (.clk(clk), .rdata(rdata), .busReq(busReq));
  task automatic finish_test();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] v);
    tests_run++;
    if (v !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic w(input logic [17:0] a, input logic [15:0] d);
    u_fce_host.wr(a, d, 1'b0);
  endtask
  task automatic st(input logic [15:0] m, input logic [15:0] e, input string nm);
    u_fce_host.rd(S, s);
    chk(nm, e, s & m);
  endtask
  task automatic stop();
    @(posedge clk);
    stopReq <= 1'b1;
    @(posedge clk);
    stopReq <= 1'b0;
  endtask
  task automatic bd();
    @(posedge clk);
    backdoorUnlock <= 1'b1;
    @(posedge clk);
    backdoorUnlock <= 1'b0;
  endtask
  // Stop closes any open sequence so each case starts clean
  task automatic idle();
    stop();
    u_fce_host.clr();
    st(16'h00f0, 16'h00c0, "flags clear");
  endtask
  task automatic rst(input logic [7:0] c);
    @(posedge clk);
    cfgLockByte <= c;
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
  endtask
  task automatic wait_idle();
    n = 0;
    while (opActive !== 1'b0) begin
      @(posedge clk);
      n++;
      #1;
      if (n > 400) begin
        errors++;
        finish_test();
      end
    end
  endtask
  initial begin
    rst(8'hfe);
    st(16'h00f4, 16'h00c0, "reset status");
    u_fce_host.rd(L, s);
    chk("lock reset", 16'h00fe, s);
    w(L, 16'h0000);
    u_fce_host.rd(L, s);
    chk("lock write", 16'h00fe, s);
    w(A, 16'h0000);
    st(16'h0010, 16'h0010, "no divider");
    idle();
    w(K, 16'h0008);
    w(18'h00002, 16'h0003);
    #1 chk("margin", 16'h0003, {14'h0, senseMargin});
    $display("test registers done");
    foreach (rows[i]) begin
      protHit <= rows[i].f[3];
      blockProtAny <= rows[i].f[2];
      u_fce_host.wr(rows[i].a1, 16'h0000, rows[i].f[4]);
      w(rows[i].a2, {8'h00, rows[i].d2});
      if (rows[i].a3 != N) w(rows[i].a3, {8'h00, rows[i].d3});
      st(16'h0030, {10'h0, rows[i].f[1:0], 4'h0}, "row flags");
      idle();
      $display("test row %0d done", i);
    end
    protHit <= 1'b0;
    blockProtAny <= 1'b0;
    w(A, 16'h0000);
    u_fce_host.launch(18'h30000, 8'h05);
    #1 chk("verify blocks", 16'h0005, {12'h0, verifySel});
    wait_idle();
    chk("verify cycles", 16'(NW + 14), 16'(n));
    st(16'h00c4, 16'h00c4, "verify blank");
    badIdx <= 15'h0005;
    u_fce_host.launch(A, 8'h05);
    #1 wait_idle();
    chk("verify stop", 16'h0006, 16'(n));
    st(16'h0044, 16'h0040, "verify unerased");
    $display("test verify done");
    u_fce_host.launch(A, 8'h06);
    w(A, 16'h0000);
    st(16'h0010, 16'h0010, "start during compress");
    idle();
    u_fce_host.launch(A, 8'h40);
    u_fce_host.launch(A, 8'h47);
    #1 chk("abort running", 16'h0147, {7'h0, opActive, activeCmd});
    st(16'h0010, 16'h0010, "abort flags");
    u_fce_host.clr();
    w(A, 16'h0000);
    st(16'h0010, 16'h0010, "start during abort");
    wait_idle();
    chk("abort early", 16'h0001, {15'h0, n < 12});
    idle();
    u_fce_host.launch(A, 8'h20);
    u_fce_host.rd(A, s);
    chk("busy array read", 16'h0000, s);
    st(16'h0050, 16'h0000, "busy read flags");
    stop();
    #1 chk("stop abort", 16'h0000, {15'h0, opActive});
    st(16'h0050, 16'h0050, "stop flags");
    idle();
    u_fce_host.rd(A, s);
    chk("idle array read", 16'h1234, s);
    $display("test operations done");
    rst(8'h00);
    w(K, 16'h0008);
    for (int m = 1; m < 3; m++) begin
      {debugMode, nonSecureSrc} <= 2'(m);
      w(A, 16'h0000);
      w(C, 16'h0020);
      st(16'h0010, 16'h0010, "secured program");
      idle();
      w(A, 16'h0000);
      w(C, 16'h0041);
      st(16'h0010, 16'h0000, "secured mass erase");
      idle();
    end
    bd();
    u_fce_host.rd(L, s);
    chk("key disabled", 16'h0000, s);
    rst(8'h80);
    bd();
    u_fce_host.rd(L, s);
    chk("key unlock", 16'h0082, s);
    $display("test security done");
    finish_test();
  end
endmodule
